// file: rtl/r2c_pkg.sv
// package: register map, field layout, defaults and codes of the regulator 2 control block
package r2c_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CONTROL = 10'h0cb;   // mode, float, voltage code
  localparam logic [9:0] IDX_TIMEOUTS = 10'h0cc;  // fault action, slots
  localparam logic [9:0] IDX_LOW_POWER = 10'h0cd; // hibernate fields, image code
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0e0; // sticky events, read clears
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0e1;   // 1 lets an event reach the irq
  localparam logic [9:0] IDX_HIBERNATE = 10'h0e2;  // hibernate bit and live state

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SWITCH_MODE_BIT = 14;
  localparam int OUTPUT_FLOAT_BIT = 10;
  localparam int VCODE_LSB = 0;
  localparam int VCODE_W = 5;
  localparam int FAULT_ACT_LSB = 14;
  localparam int STARTUP_LSB = 10;
  localparam int SHUTDOWN_LSB = 6;
  localparam int SLOT_W = 4;
  localparam int HIB_BEHAV_LSB = 12;
  localparam int HIB_SRC_LSB = 8;
  localparam int EV_FAULT_BIT = 0;
  localparam int EV_SYSDOWN_BIT = 1;
  localparam int EV_W = 2;

  // ---------------------------------------------------------------
  // writable bits and defaults
  // ---------------------------------------------------------------
  localparam logic [15:0] CONTROL_WMASK = 16'h441f;
  localparam logic [15:0] TIMEOUTS_WMASK = 16'hffc0;
  localparam logic [15:0] LOW_POWER_WMASK = 16'h331f;
  localparam logic [15:0] CONTROL_DEFAULT = 16'h001b;
  localparam logic [15:0] TIMEOUTS_DEFAULT = 16'h0000;
  localparam logic [15:0] LOW_POWER_DEFAULT = 16'h001c;
  localparam logic [EV_W-1:0] IRQ_MASK_DEFAULT = 2'h3;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SLOT_NONE = 4'h0;    // start-up: never; shutdown: on off entry
  localparam logic [3:0] SLOT_STATE = 4'hf;   // on active entry / on off entry
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_REG_DOWN = 2'h1;
  localparam logic [1:0] HIB_IMAGE = 2'h0;
  localparam logic [1:0] HIB_DISABLE = 2'h1;
  localparam logic [1:0] SRC_REG_BIT = 2'h0;

endpackage : r2c_pkg

// file: rtl/r2c_regs.sv
// regulator 2 control registers, slot sequencing, fault reaction and hibernate over apb
//
// Behaviour
// - mode bit 14: regulate or current-limited switch
// - bit 10: discharge disabled output, or float
// - all four regulators off forces discharge
// - 5-bit voltage code, 0.9V to 3.3V
// - fault action: ignore, regulator off, system off
// - every fault raises an interrupt event
// - start-up slot: off, slot 1-14, active
// - shutdown slot: slot 1-14, else off entry
// - hibernate: image voltage or disable output
// - hibernate source: register bit or low-power input
// - image code applies while hibernating in image mode
// - state machine reset restores variant defaults
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module r2c_regs #(
  parameter logic [15:0] CONTROL_RESET = r2c_pkg::CONTROL_DEFAULT,     // per-variant default
  parameter logic [15:0] TIMEOUTS_RESET = r2c_pkg::TIMEOUTS_DEFAULT,   // per-variant default
  parameter logic [15:0] LOW_POWER_RESET = r2c_pkg::LOW_POWER_DEFAULT  // per-variant default
) (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // power sequencer, same clock
  input wire logic SEQ_SLOT_STROBE_IN,
  input wire logic [3:0] SEQ_SLOT_IN,
  input wire logic SEQ_ENTER_ACTIVE_IN,
  input wire logic SEQ_ENTER_OFF_IN,
  input wire logic SEQ_SHUTDOWN_RUN_IN,  // level: strobed slots belong to a shutdown run
  input wire logic SEQ_STATE_RESET_IN,
  input wire logic OTHER_REGS_ALL_OFF_IN,
  // asynchronous pins
  input wire logic REG2_FAULT_IN,
  input wire logic [2:0] LOW_POWER_INPUT_IN,
  // analogue regulator controls
  output logic REG2_ENABLE_OUT,
  output logic REG2_DISCHARGE_OUT,
  output logic REG2_SWITCH_MODE_OUT,
  output logic [4:0] REG2_VOLTAGE_CODE_OUT,
  output logic REG2_HIBERNATE_OUT,
  output logic SYS_SHUTDOWN_OUT,
  // interrupt
  output logic IRQ_OUT
);
  import r2c_pkg::*;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  // defaults may only set bits that exist in the registers
  if (((CONTROL_RESET & ~CONTROL_WMASK) | (TIMEOUTS_RESET & ~TIMEOUTS_WMASK)
    | (LOW_POWER_RESET & ~LOW_POWER_WMASK)) != 16'h0000)
  begin : g_bad_default
    $error("register default sets unused bits");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] control_r, control_nxt;     // regulator mode and voltage
  logic [15:0] timeouts_r, timeouts_nxt;   // fault action and slots
  logic [15:0] low_power_r, low_power_nxt; // hibernate setup
  logic [EV_W-1:0] status_r, status_nxt;   // sticky events
  logic [EV_W-1:0] mask_r, mask_nxt;       // interrupt mask
  logic hib_bit_r, hib_bit_nxt;            // software hibernate request
  logic run_r, run_nxt;                    // sequencer-driven enable
  logic fault_meta_r, fault_sync_r;        // fault synchroniser
  logic fault_prev_r;                      // for edge detect
  logic [2:0] lp_meta_r, lp_sync_r;        // low-power input synchroniser
  logic pready_r, pslverr_r;               // apb answer
  logic [31:0] prdata_r;
  logic en_out_r, dis_out_r, sw_out_r, hib_out_r, sys_out_r, irq_r;
  logic [4:0] vcode_out_r;

  // ---------------------------------------------------------------
  // field views
  // ---------------------------------------------------------------
  wire logic sw_mode = control_r[SWITCH_MODE_BIT];
  wire logic out_float = control_r[OUTPUT_FLOAT_BIT];
  wire logic [VCODE_W-1:0] vcode = control_r[VCODE_LSB +: VCODE_W];
  wire logic [1:0] fault_act = timeouts_r[FAULT_ACT_LSB +: 2];
  wire logic [SLOT_W-1:0] up_slot = timeouts_r[STARTUP_LSB +: SLOT_W];
  wire logic [SLOT_W-1:0] down_slot = timeouts_r[SHUTDOWN_LSB +: SLOT_W];
  wire logic [1:0] hib_behav = low_power_r[HIB_BEHAV_LSB +: 2];
  wire logic [1:0] hib_src = low_power_r[HIB_SRC_LSB +: 2];
  wire logic [VCODE_W-1:0] img_code = low_power_r[VCODE_LSB +: VCODE_W];
  // source 0 is the register bit, 1..3 the synchronised low-power inputs
  wire logic hib_active =
    (hib_src == SRC_REG_BIT) ? hib_bit_r : lp_sync_r[hib_src - 2'h1];

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  // two-cycle access: first access cycle loads read data, second completes
  wire logic [9:0] idx = PADDR_IN[11:2];
  wire logic access = PSEL_IN & PENABLE_IN;
  wire logic done = access & pready_r;           // the edge that commits
  wire logic wr_done = done & PWRITE_IN;
  wire logic rd_done = done & ~PWRITE_IN;
  wire logic hit_ctrl = (idx == IDX_CONTROL);
  wire logic hit_tmo = (idx == IDX_TIMEOUTS);
  wire logic hit_lp = (idx == IDX_LOW_POWER);
  wire logic hit_stat = (idx == IDX_IRQ_STATUS);
  wire logic hit_mask = (idx == IDX_IRQ_MASK);
  wire logic hit_hib = (idx == IDX_HIBERNATE);
  wire logic mapped = hit_ctrl | hit_tmo | hit_lp | hit_stat | hit_mask | hit_hib;
  wire logic [15:0] wdata = PWDATA_IN[15:0];

  // read mux; unmapped reads give zero with an error flag
  wire logic [15:0] rd_mux =
    hit_ctrl ? control_r :
    hit_tmo ? timeouts_r :
    hit_lp ? low_power_r :
    hit_stat ? {14'h0000, status_r} :
    hit_mask ? {14'h0000, mask_r} :
    hit_hib ? {13'h0000, en_out_r, hib_active, hib_bit_r} :
    16'h0000;

  // ---------------------------------------------------------------
  // fault reaction
  // ---------------------------------------------------------------
  wire logic fault_ev = fault_sync_r & ~fault_prev_r; // one event per fault
  wire logic reg_down = fault_ev & (fault_act == ACT_REG_DOWN);
  wire logic sys_down = fault_ev & fault_act[1];  // 10 and 11 alike

  // ---------------------------------------------------------------
  // slot matching
  // ---------------------------------------------------------------
  // slots 1..14 match the strobe of the matching run only, else a shutdown
  // slot would also fire during start-up; 0 and 15 are state codes
  wire logic up_is_slot = (up_slot != SLOT_NONE) & (up_slot != SLOT_STATE);
  wire logic down_is_slot = (down_slot != SLOT_NONE) & (down_slot != SLOT_STATE);
  wire logic up_hit =
    (SEQ_SLOT_STROBE_IN & ~SEQ_SHUTDOWN_RUN_IN & up_is_slot & (SEQ_SLOT_IN == up_slot)) |
    (SEQ_ENTER_ACTIVE_IN & (up_slot == SLOT_STATE));
  wire logic down_hit =
    (SEQ_SLOT_STROBE_IN & SEQ_SHUTDOWN_RUN_IN & down_is_slot & (SEQ_SLOT_IN == down_slot)) |
    (SEQ_ENTER_OFF_IN & ~down_is_slot);

  // ---------------------------------------------------------------
  // output derivation
  // ---------------------------------------------------------------
  // hibernate in disable mode masks the enable; reserved modes act as normal
  wire logic hib_off = hib_active & (hib_behav == HIB_DISABLE);
  wire logic hib_img = hib_active & (hib_behav == HIB_IMAGE);
  wire logic en_nxt = run_nxt & ~hib_off;
  // floating only allowed while some other regulator stays up
  wire logic dis_nxt = ~en_nxt & (~out_float | OTHER_REGS_ALL_OFF_IN);
  // in switch mode the code is meaningless; drive zero so nothing reads it
  wire logic [4:0] vcode_nxt =
    sw_mode ? 5'h00 : (hib_img ? img_code : vcode);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    control_nxt = control_r;
    timeouts_nxt = timeouts_r;
    low_power_nxt = low_power_r;
    mask_nxt = mask_r;
    hib_bit_nxt = hib_bit_r;
    status_nxt = status_r;
    run_nxt = run_r;
    // software writes
    if (wr_done)
    begin
      if (hit_ctrl)
      begin
        control_nxt = wdata & CONTROL_WMASK;
      end
      if (hit_tmo)
      begin
        timeouts_nxt = wdata & TIMEOUTS_WMASK;
      end
      if (hit_lp)
      begin
        low_power_nxt = wdata & LOW_POWER_WMASK;
      end
      if (hit_mask)
      begin
        mask_nxt = wdata[EV_W-1:0];
      end
      if (hit_hib)
      begin
        hib_bit_nxt = wdata[0];
      end
    end
    // read of status clears it
    if (rd_done & hit_stat)
    begin
      status_nxt = '0;
    end
    // new events win over the clear
    if (fault_ev)
    begin
      status_nxt[EV_FAULT_BIT] = 1'b1;
    end
    if (sys_down)
    begin
      status_nxt[EV_SYSDOWN_BIT] = 1'b1;
    end
    // sequencer: shutdown beats start-up in the same cycle
    if (up_hit)
    begin
      run_nxt = 1'b1;
    end
    if (down_hit | reg_down | sys_down)
    begin
      run_nxt = 1'b0;
    end
    // power state machine reset restores the variant defaults
    if (SEQ_STATE_RESET_IN)
    begin
      control_nxt = CONTROL_RESET;
      timeouts_nxt = TIMEOUTS_RESET;
      low_power_nxt = LOW_POWER_RESET;
      run_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  // first stage read only by the second
  always_ff @(posedge REF_CLK_IN)
  begin
    fault_meta_r <= REG2_FAULT_IN;
    fault_sync_r <= fault_meta_r;
    lp_meta_r <= LOW_POWER_INPUT_IN;
    lp_sync_r <= lp_meta_r;
  end

  // ---------------------------------------------------------------
  // configuration and control registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      control_r <= CONTROL_RESET;
      timeouts_r <= TIMEOUTS_RESET;
      low_power_r <= LOW_POWER_RESET;
      status_r <= '0;
      mask_r <= IRQ_MASK_DEFAULT;
      hib_bit_r <= 1'b0;
      run_r <= 1'b0;
      fault_prev_r <= 1'b0;
    end
    else
    begin
      control_r <= control_nxt;
      timeouts_r <= timeouts_nxt;
      low_power_r <= low_power_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      hib_bit_r <= hib_bit_nxt;
      run_r <= run_nxt;
      fault_prev_r <= fault_sync_r;
    end
  end

  // ---------------------------------------------------------------
  // apb answer registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      // ready for exactly one cycle, in the second access cycle
      pready_r <= access & ~pready_r;
      pslverr_r <= access & ~pready_r & ~mapped;
      prdata_r <= (access & ~pready_r & ~PWRITE_IN) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // regulator and interrupt outputs
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      en_out_r <= 1'b0;
      dis_out_r <= 1'b1;                // off and pulled down from reset
      sw_out_r <= 1'b0;
      vcode_out_r <= 5'h00;
      hib_out_r <= 1'b0;
      sys_out_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      en_out_r <= en_nxt;
      dis_out_r <= dis_nxt;
      sw_out_r <= sw_mode;              // same cycle as the zeroed code
      vcode_out_r <= vcode_nxt;
      hib_out_r <= hib_active;
      sys_out_r <= sys_down;            // one-cycle request to the sequencer
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  // ---------------------------------------------------------------
  // port drive
  // ---------------------------------------------------------------
  assign PRDATA_OUT = prdata_r;
  assign PREADY_OUT = pready_r;
  assign PSLVERR_OUT = pslverr_r;
  assign REG2_ENABLE_OUT = en_out_r;
  assign REG2_DISCHARGE_OUT = dis_out_r;
  assign REG2_SWITCH_MODE_OUT = sw_out_r;
  assign REG2_VOLTAGE_CODE_OUT = vcode_out_r;
  assign REG2_HIBERNATE_OUT = hib_out_r;
  assign SYS_SHUTDOWN_OUT = sys_out_r;
  assign IRQ_OUT = irq_r;

endmodule : r2c_regs

`default_nettype wire

// file: verification/r2c_monitor.sv
// assertion checker for the regulator 2 control block
`timescale 1ns/1ns
`default_nettype none
module r2c_monitor (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // apb and sequencer
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic SEQ_SLOT_STROBE_IN,
  input wire logic SEQ_ENTER_ACTIVE_IN,
  input wire logic OTHER_REGS_ALL_OFF_IN,
  // regulator outputs
  input wire logic REG2_ENABLE_OUT,
  input wire logic REG2_DISCHARGE_OUT,
  input wire logic REG2_SWITCH_MODE_OUT,
  input wire logic [4:0] REG2_VOLTAGE_CODE_OUT,
  input wire logic REG2_HIBERNATE_OUT,
  input wire logic SYS_SHUTDOWN_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ---------------------------------------------------------------
  // bus handshake steps
  // ---------------------------------------------------------------
  sequence s_wait; PSEL_IN && PENABLE_IN && !PREADY_OUT; endsequence
  sequence s_done; PREADY_OUT ##1 !PREADY_OUT; endsequence
  property p_wait; s_wait |=> s_done; endproperty
  a_wait: assert property (p_wait) else $error("ready not one cycle after access");
  property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_hi; PREADY_OUT |-> PRDATA_OUT[31:16] == 16'h0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read half not zero");
  // ---------------------------------------------------------------
  // regulator controls
  // ---------------------------------------------------------------
  property p_sw; REG2_SWITCH_MODE_OUT |-> REG2_VOLTAGE_CODE_OUT == 5'h00; endproperty
  a_sw: assert property (p_sw) else $error("code not zero in switch mode");
  property p_dis_on; REG2_ENABLE_OUT |-> !REG2_DISCHARGE_OUT; endproperty
  a_dis_on: assert property (p_dis_on) else $error("discharge while enabled");
  property p_all_off; $past(OTHER_REGS_ALL_OFF_IN) && !REG2_ENABLE_OUT |-> REG2_DISCHARGE_OUT; endproperty
  a_all_off: assert property (p_all_off) else $error("no discharge with all off");
  property p_sys; SYS_SHUTDOWN_OUT |-> !REG2_ENABLE_OUT ##1 !SYS_SHUTDOWN_OUT; endproperty
  a_sys: assert property (p_sys) else $error("bad system shutdown pulse");
  // hibernate release may also restore the enable, so it is excluded
  property p_up;
    $rose(REG2_ENABLE_OUT) && !$past(REG2_HIBERNATE_OUT) && !$past(REG2_HIBERNATE_OUT, 2)
      |-> $past(SEQ_SLOT_STROBE_IN) || $past(SEQ_ENTER_ACTIVE_IN);
  endproperty
  a_up: assert property (p_up) else $error("enable rose without sequencer step");
endmodule : r2c_monitor
bind r2c_regs r2c_monitor u_mon (.REF_CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT,
  .PSLVERR_OUT, .PRDATA_OUT, .SEQ_SLOT_STROBE_IN, .SEQ_ENTER_ACTIVE_IN, .OTHER_REGS_ALL_OFF_IN,
  .REG2_ENABLE_OUT, .REG2_DISCHARGE_OUT, .REG2_SWITCH_MODE_OUT, .REG2_VOLTAGE_CODE_OUT,
  .REG2_HIBERNATE_OUT, .SYS_SHUTDOWN_OUT);
`default_nettype wire

// file: verification/r2c_seq_model.sv
// power sequencer model: walks slots 1..14, then enters active or off
`timescale 1ns/1ns
`default_nettype none
module r2c_seq_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic up_in,      // pulse: start-up run
  input wire logic down_in,    // pulse: shutdown run
  input wire logic slow_in,    // idle cycle between slots
  output logic strobe_out,
  output logic [3:0] slot_out,
  output logic enter_active_out,
  output logic enter_off_out,
  output logic down_run_out    // level: slots walked belong to a shutdown run
);
  logic [3:0] step_r = 4'h0;  // 0 idle, 15 state entry
  logic stb_r = 1'b0, act_r = 1'b0, off_r = 1'b0, dir_r = 1'b0, gap_r = 1'b0;
  logic [3:0] slot_r = 4'h0;
  assign strobe_out = stb_r;
  assign slot_out = slot_r;
  assign enter_active_out = act_r;
  assign enter_off_out = off_r;
  assign down_run_out = !dir_r;
  // one slot per strobe; slot lines toggle outside strobes, they carry nothing then
  always @(posedge clk_in)
  begin
    stb_r <= 1'b0;
    act_r <= 1'b0;
    off_r <= 1'b0;
    slot_r <= ~slot_r;
    if (!rst_n_in)
      step_r <= 4'h0;
    else if (up_in || down_in)
    begin
      step_r <= 4'h1;
      dir_r <= up_in;
    end
    else if (step_r == 4'hf)
    begin
      act_r <= dir_r;
      off_r <= !dir_r;
      step_r <= 4'h0;
    end
    else if (step_r != 4'h0 && !gap_r)
    begin
      stb_r <= 1'b1;  // slot index matched by the block
      slot_r <= step_r;
      step_r <= step_r + 4'h1;
      gap_r <= slow_in;
    end
    else
      gap_r <= 1'b0;
  end
endmodule : r2c_seq_model
`default_nettype wire

// file: verification/test_r2c_regs.sv
// self-checking testbench of the regulator 2 control block
`timescale 1ns/1ns
`default_nettype none
module test_r2c_regs;
  import r2c_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'd94;
  logic pready, pslverr, strobe, ena, eoff, drun, en, dis, sw, hib, sys, irq;
  logic sreset = 1'b0, all_off = 1'b0, fault = 1'b0, up = 1'b0, down = 1'b0, slow = 1'b0;
  logic [3:0] slot, c;
  logic [4:0] vc;
  logic [2:0] lp = 3'h0;
  logic [33:0] e;
  logic [33:0] expq[$];  // {read, error, data} notes
  int n_fail = 0, checks = 0, nsys = 0, armed = 0;
  always #4 clk = ~clk;
  r2c_regs u_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SEQ_SLOT_STROBE_IN(strobe), .SEQ_SLOT_IN(slot), .SEQ_ENTER_ACTIVE_IN(ena),
    .SEQ_ENTER_OFF_IN(eoff), .SEQ_SHUTDOWN_RUN_IN(drun), .SEQ_STATE_RESET_IN(sreset),
    .OTHER_REGS_ALL_OFF_IN(all_off),
    .REG2_FAULT_IN(fault), .LOW_POWER_INPUT_IN(lp), .REG2_ENABLE_OUT(en), .REG2_DISCHARGE_OUT(dis),
    .REG2_SWITCH_MODE_OUT(sw), .REG2_VOLTAGE_CODE_OUT(vc), .REG2_HIBERNATE_OUT(hib),
    .SYS_SHUTDOWN_OUT(sys), .IRQ_OUT(irq));
  r2c_seq_model u_seq (.clk_in(clk), .rst_n_in(rst_n), .up_in(up), .down_in(down), .slow_in(slow),
    .strobe_out(strobe), .slot_out(slot), .enter_active_out(ena), .enter_off_out(eoff),
    .down_run_out(drun));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one apb transfer; the expected answer is noted before the request goes out
  task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d, input logic er,
    input logic [15:0] x);
    expq.push_back({~w, er, 16'h0, x});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {rnd[31:16], d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, 1'b0, 16'h0);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [15:0] x);
    apb(1'b0, idx, 16'h0, 1'b0, x);
  endtask : rd
  task automatic defaults;
    rd(IDX_CONTROL, CONTROL_DEFAULT);
    rd(IDX_TIMEOUTS, TIMEOUTS_DEFAULT);
    rd(IDX_LOW_POWER, LOW_POWER_DEFAULT);
  endtask : defaults
  // sequencer run, up or down, long enough for a slow walk
  task automatic run(input logic u);
    @(posedge clk);
    up <= u;
    down <= ~u;
    @(posedge clk);
    up <= 1'b0;
    down <= 1'b0;
    cyc(40);
    armed = 0;
  endtask : run
  // apb answer watcher: compares each completion with the oldest note
  always @(posedge clk)
    if (psel && penable && pready === 1'b1)
    begin
      if (expq.size() == 0)
        chk(32'h0, 32'h1);
      e = expq.pop_front();
      chk(pslverr, e[32]);
      if (e[33])
        chk(prdata, e[31:0]);
    end
  // enable against the slot being strobed, the edge after its slot
  always @(posedge clk)
  begin
    if (sys === 1'b1)
      nsys++;
    if (armed != 0 && strobe)
      chk(en, (armed == 1) ? (slot > c) : (slot <= ~c));
  end
  initial
  begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    cyc(2);
    rst_n <= 1'b1;
    defaults();
    rd(IDX_IRQ_MASK, {14'h0, IRQ_MASK_DEFAULT});
    chk(vc, CONTROL_DEFAULT[4:0]);
    for (int i = 0; i < 3; i++)
    begin
      rnd = xs(rnd);
      wr(IDX_CONTROL + 10'(i), rnd[15:0]);
      rd(IDX_CONTROL + 10'(i), rnd[15:0] & ((i == 0) ? CONTROL_WMASK : (i == 1) ? TIMEOUTS_WMASK
        : LOW_POWER_WMASK));
    end
    apb(1'b1, 10'h0d0, 16'hffff, 1'b1, 16'h0);
    apb(1'b0, 10'h0d0, 16'h0, 1'b1, 16'h0);
    wr(IDX_IRQ_STATUS, 16'hffff);
    rd(IDX_IRQ_STATUS, 16'h0);
    rnd = xs(rnd);
    wr(IDX_CONTROL, {11'h0, rnd[4:0]});
    cyc(2);
    chk(vc, rnd[4:0]);
    wr(IDX_CONTROL, {11'h200, rnd[4:0]});
    cyc(2);
    chk({sw, vc}, 6'h20);
    wr(IDX_CONTROL, 16'h0000);
    // start-up never, a random slot, on active entry; shutdown codes mirrored
    for (int k = 0; k < 3; k++)
    begin
      rnd = xs(rnd);
      c = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 + 4'(rnd[3:0] % 4'he) : 4'hf;
      slow <= rnd[4];
      wr(IDX_TIMEOUTS, {2'b00, c, ~c, 6'h0});
      armed = (k == 1) ? 1 : 0;
      run(1'b1);
      chk(en, c != 4'h0);
      armed = (k == 1) ? 2 : 0;
      run(1'b0);
      chk({en, dis}, 2'b01);
    end
    wr(IDX_CONTROL, 16'h0400);
    cyc(2);
    chk(dis, 1'b0);
    all_off <= 1'b1;
    cyc(2);
    chk(dis, 1'b1);
    all_off <= 1'b0;
    // every fault action, then ignore with the mask clear; the interrupt comes whatever the action unless masked
    for (int k = 0; k < 5; k++)
    begin
      wr(IDX_TIMEOUTS, {2'(k), 4'hf, 4'h0, 6'h0});
      wr(IDX_IRQ_MASK, (k == 4) ? 16'h0 : 16'h3);
      run(1'b1);
      fault <= 1'b1;
      cyc(6);
      fault <= 1'b0;
      chk({irq, en}, {k != 4, k % 4 == 0});
      wr(IDX_IRQ_MASK, 16'h3);
      cyc(2);
      rd(IDX_IRQ_STATUS, {14'h0, k == 2 || k == 3, 1'b1});
      cyc(1);
      chk(irq, 1'b0);
    end
    chk(nsys, 2);
    run(1'b1);
    // hibernate from each source, image and disable behaviour
    for (int s = 0; s < 4; s++)
    begin
      rnd = xs(rnd);
      wr(IDX_LOW_POWER, {2'b00, 1'b0, s[0], 2'b00, 2'(s), 3'b000, rnd[4:0]});
      if (s == 0)
        wr(IDX_HIBERNATE, 16'h1);
      lp <= 3'(s == 0 ? 0 : 1 << (s - 1));
      cyc(4);
      chk({hib, en}, {1'b1, !s[0]});
      if (!s[0])
        chk(vc, rnd[4:0]);
      wr(IDX_HIBERNATE, 16'h0);
      lp <= 3'h0;
      cyc(4);
      chk({hib, en}, 2'b01);
    end
    sreset <= 1'b1;
    cyc(1);
    sreset <= 1'b0;
    cyc(2);
    chk(en, 1'b0);
    defaults();
    cyc(2);
    report_and_stop();
  end
endmodule : test_r2c_regs
`default_nettype wire
